// ### dv/lae_asserts.sv
// Purpose: port checks on the logical AND executor
// Assumes: clkEn held high
// Notes:   opQ follows the opcode of the instruction in flight
`timescale 1ns/1ps
`include "lae_cfg.svh"
module lae_asserts (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       fetchValid,
    input wire logic       fetchReady,
    input wire logic [7:0] fetchByte,
    input wire logic [1:0] regBank,
    input wire logic [7:0] accumulatorReg,
    input wire logic       memRdEn,
    input wire logic       memWrEn,
    input wire logic [7:0] memAddr,
    input wire logic       memIndirect,
    input wire logic       memLatch,
    input wire logic [7:0] memRdData,
    input wire logic       bitRdEn,
    input wire logic       bitRdData,
    input wire logic       accWrEn,
    input wire logic [7:0] accWrData,
    input wire logic       carryWrEn,
    input wire logic       carryWrData,
    input wire logic       instDone,
    input wire logic       illegalOp
);
    logic [7:0] opQ;
    logic       firstQ;
    wire        take  = fetchValid && fetchReady;
    wire        start = firstQ || instDone || illegalOp;
    wire        bitOp = opQ == `LAE_OPC_BIT || opQ == `LAE_OPC_BIT_NOT;
    wire        inv   = opQ == `LAE_OPC_BIT_NOT;
    // a done pulse lets the next opcode be taken on the same edge
    always_ff @(posedge clock) begin
        if (rst) begin
            firstQ <= 1'b1;
            opQ    <= 8'h00;
        end else if (take && start) begin
            firstQ <= 1'b0;
            opQ    <= fetchByte;
        end else if (instDone || illegalOp) begin
            firstQ <= 1'b1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_src0; bitRdEn ##1 (bitRdData == inv); endsequence
    sequence s_src1; bitRdEn ##1 (bitRdData != inv); endsequence
    property p_bit_clear; s_src0 |=> carryWrEn && !carryWrData && instDone; endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("carry not cleared");
    property p_bit_keep; s_src1 |=> !carryWrEn && instDone; endproperty
    a_bit_keep: assert property (p_bit_keep) else $error("carry changed");
    property p_bit_only; instDone && bitOp |-> !accWrEn && !memWrEn; endproperty
    a_bit_only: assert property (p_bit_only) else $error("bit form wrote a byte");
    property p_carry_byte; carryWrEn |-> bitOp; endproperty
    a_carry_byte: assert property (p_carry_byte) else $error("byte form wrote carry");
    property p_rmw; memWrEn |-> memLatch && !memIndirect && $stable(memAddr) && $past(memRdEn, 2); endproperty
    a_rmw: assert property (p_rmw) else $error("write without latch read");
    property p_imm;
        take && !start && opQ == `LAE_OPC_ACC_IMM |-> ##2 accWrEn && accWrData == (accumulatorReg & $past(fetchByte, 2));
    endproperty
    a_imm: assert property (p_imm) else $error("immediate result wrong");
    property p_acc_rd;
        memRdEn && (memIndirect || opQ == `LAE_OPC_ACC_DIR || opQ[7:3] == 5'h0b)
            |-> ##2 accWrEn && accWrData == (accumulatorReg & $past(memRdData));
    endproperty
    a_acc_rd: assert property (p_acc_rd) else $error("read result wrong");
    property p_reg_addr; memRdEn && opQ[7:3] == 5'h0b |-> memAddr == {3'h0, regBank, opQ[2:0]} && !memIndirect; endproperty
    a_reg_addr: assert property (p_reg_addr) else $error("register address wrong");
    property p_ind; memRdEn && memIndirect |-> opQ[7:1] == 7'h2b && memAddr == $past(memRdData); endproperty
    a_ind: assert property (p_ind) else $error("indirect address wrong");
endmodule

bind logical_and_execute lae_asserts u_lae_asserts (.clock, .rst, .fetchValid, .fetchReady, .fetchByte, .regBank,
    .accumulatorReg, .memRdEn, .memWrEn, .memAddr, .memIndirect, .memLatch, .memRdData, .bitRdEn, .bitRdData,
    .accWrEn, .accWrData, .carryWrEn, .carryWrData, .instDone, .illegalOp);

// ### dv/lae_prog_mem.sv
// Purpose: program, data and bit memory beside the executor
// Assumes: bench pushes program bytes and fills ram and bits
// Notes:   unanswered lines show the inverse of their last value
`timescale 1ns/1ps
module lae_prog_mem (
    input  wire logic       clock,
    input  wire logic       rst,
    output logic            fetchValid,
    output logic [7:0]      fetchByte,
    input  wire logic       fetchReady,
    input  wire logic       memRdEn,
    input  wire logic       memWrEn,
    input  wire logic [7:0] memAddr,
    input  wire logic [7:0] memWrData,
    output logic [7:0]      memRdData,
    input  wire logic       bitRdEn,
    input  wire logic [7:0] bitAddr,
    output logic            bitRdData
);
    logic [7:0] prog[$];
    logic [7:0] ram[256];
    logic       bits[256];
    int         head = 0;
    initial begin
        fetchValid = 1'b0;
        fetchByte = 8'h00;
        memRdData = 8'h00;
        bitRdData = 1'b0;
    end
    // one-cycle answers only: the executor has no wait input
    always @(posedge clock) begin
        if (!rst && fetchValid && fetchReady)
            head = head + 1;
        fetchValid <= !rst && head < prog.size();
        fetchByte <= head < prog.size() ? prog[head] : ~fetchByte;
        memRdData <= memRdEn ? ram[memAddr] : ~memRdData;
        bitRdData <= bitRdEn ? bits[bitAddr] : ~bitRdData;
        if (memWrEn)
            ram[memAddr] <= memWrData;
    end
endmodule

// ### dv/logical_and_execute_tb.sv
// Purpose: random and corner runs of the logical AND executor
// Assumes: clkEn held high, partner answers in one cycle
// Notes:   accumulator modelled here, memories in the partner
`timescale 1ns/1ps
module logical_and_execute_tb;
    logic       clock, rst, clkEn, fetchValid, fetchReady, memRdEn, memWrEn, memIndirect, memLatch, bitRdEn;
    logic       bitRdData, accWrEn, carryWrEn, carryWrData, instDone, illegalOp;
    logic [7:0] fetchByte, memAddr, memWrData, memRdData, bitAddr, accWrData, accumulatorReg, accModel, v;
    logic [1:0] regBank, instBytes, instCycles;
    int         n_fail = 0;
    int         checks_done = 0;
    logic [7:0] ops[16] = '{8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f,
                            8'h56, 8'h57, 8'h55, 8'h54, 8'h52, 8'h53, 8'h82, 8'hb0};
    logic [7:0] bad[4] = '{8'h50, 8'h51, 8'h83, 8'hb1};
    logical_and_execute u_logical_and_execute (.clock, .rst, .clkEn, .fetchValid, .fetchByte, .fetchReady, .regBank,
        .accumulatorReg, .memRdEn, .memWrEn, .memAddr, .memIndirect, .memLatch, .memWrData, .memRdData, .bitRdEn,
        .bitAddr, .bitRdData, .accWrEn, .accWrData, .carryWrEn, .carryWrData, .instDone, .illegalOp, .instBytes,
        .instCycles);
    lae_prog_mem u_lae_prog_mem (.clock, .rst, .fetchValid, .fetchByte, .fetchReady, .memRdEn, .memWrEn, .memAddr,
        .memWrData, .memRdData, .bitRdEn, .bitAddr, .bitRdData);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    function automatic logic [7:0] m(input logic [7:0] a);
        return u_lae_prog_mem.ram[a];
    endfunction
    // wide enough that packed groups of outputs are compared whole
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input logic reload);
        logic [7:0] a, ex;
        logic [1:0] rb, nb, nc;
        logic       wa, wm, clr;
        int         k;
        // one edge first so a pending memory write has landed
        @(negedge clock);
        rb = 2'($urandom);
        a = reload ? 8'($urandom) : accModel;
        {wa, wm, clr, nb, nc} = {3'b100, 2'h2, 2'h1};
        case (op)
            8'h55: ex = a & m(b2);
            8'h54: ex = a & b2;
            8'h52: {wa, wm, ex} = {2'b01, m(b2) & a};
            8'h53: {wa, wm, nb, nc, ex} = {6'b011110, m(b2) & b3};
            8'h82, 8'hb0: {wa, nc, clr} = {3'b010, ~(u_lae_prog_mem.bits[b2] ^ (op == 8'hb0))};
            default: {nb, ex} = {2'h1, a & m(op[3] ? {3'h0, rb, op[2:0]} : m({3'h0, rb, 2'h0, op[0]}))};
        endcase
        @(posedge clock);
        regBank <= rb;
        accumulatorReg <= a;
        u_lae_prog_mem.prog.push_back(op);
        if (nb > 2'h1)
            u_lae_prog_mem.prog.push_back(b2);
        if (nb > 2'h2)
            u_lae_prog_mem.prog.push_back(b3);
        @(negedge clock);
        for (k = 0; k < 20 && instDone !== 1'b1; k++)
            @(negedge clock);
        check(instDone, 1'b1);
        check(instBytes, nb);
        check(instCycles, nc);
        check({accWrEn, memWrEn, carryWrEn}, {wa, wm, clr});
        if (wa)
            check(accWrData, ex);
        if (wm)
            check({memWrData, memAddr, memLatch}, {ex, b2, 1'b1});
        if (op[7])
            check({carryWrData, bitAddr}, {1'b0, b2});
        accModel = wa ? ex : a;
    endtask
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        regBank = 2'h0;
        accumulatorReg = 8'h00;
        accModel = 8'h00;
        void'($urandom(32'h270fabb2));
        for (int i = 0; i < 256; i++)
            {u_lae_prog_mem.ram[i], u_lae_prog_mem.bits[i]} = 9'($urandom);
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            if (r == 4) begin
                @(posedge clock);
                rst <= 1'b1;
                repeat (2) @(negedge clock);
                check({instDone, accWrEn, memWrEn, carryWrEn, illegalOp, fetchReady}, 8'h00);
                @(posedge clock);
                rst <= 1'b0;
            end
            // rounds 1 and 2 push boundary bytes as address and constant; round 3 pairs a byte with its complement
            for (int i = 0; i < 16; i++) begin
                v = r == 1 ? 8'hff : r == 2 ? 8'h00 : 8'($urandom);
                run(ops[i], v, r == 3 ? ~v : 8'($urandom), r[0]);
            end
        end
        foreach (bad[j]) begin
            @(posedge clock);
            u_lae_prog_mem.prog.push_back(bad[j]);
            v = 8'h00;
            // dropped opcode: one illegal pulse, no write and no done
            repeat (6) begin
                @(negedge clock);
                v = v | {3'h0, illegalOp, instDone, accWrEn, memWrEn, carryWrEn};
            end
            check(v, 8'h10);
            check(fetchReady, 1'b1);
        end
        complete_run();
    end
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule

// ### verilog/lae_cfg.svh
// Purpose: opcode encodings, lengths and machine-cycle counts for the logical AND group
// Assumes: included by the decoder, the executor and the assertion module that need the numbers
// Notes:   definitions only
`ifndef LAE_CFG_SVH
`define LAE_CFG_SVH

`define LAE_OPC_ACC_REG      8'h58
`define LAE_OPC_ACC_REG_MASK 8'hf8
`define LAE_OPC_ACC_DIR      8'h55
`define LAE_OPC_ACC_IND      8'h56
`define LAE_OPC_ACC_IND_MASK 8'hfe
`define LAE_OPC_ACC_IMM      8'h54
`define LAE_OPC_DIR_ACC      8'h52
`define LAE_OPC_DIR_IMM      8'h53
`define LAE_OPC_BIT          8'h82
`define LAE_OPC_BIT_NOT      8'hb0

`define LAE_LEN_ONE          2'h1
`define LAE_LEN_TWO          2'h2
`define LAE_LEN_THREE        2'h3
`define LAE_CYC_ONE          2'h1
`define LAE_CYC_TWO          2'h2

`define LAE_RST_BYTE         8'h00
`define LAE_RST_BANK_ADDR    3'h0

`endif

// ### verilog/lae_dec_if.sv
// Purpose: carries an opcode to the decoder and its decoded class back
// Assumes: purely combinational path
// Notes:   none
`timescale 1ns/1ps
interface lae_dec_if;
    import lae_pkg::*;
    logic [7:0] opcode;
    lae_kind_t  kind;
    logic [1:0] lenBytes;
    logic [1:0] machCycles;
    logic [2:0] regIdx;

    modport exec (output opcode, input kind, input lenBytes, input machCycles, input regIdx);
    modport dec  (input opcode, output kind, output lenBytes, output machCycles, output regIdx);
endinterface

// ### verilog/lae_decode.sv
// Purpose: classifies an opcode byte of the logical AND group
// Assumes: opcode stable while the executor samples the result
// Notes:   anything outside the group decodes as none
`timescale 1ns/1ps
`include "lae_cfg.svh"
module lae_decode (
    lae_dec_if.dec d
);
    import lae_pkg::*;

    always_comb begin
        d.kind       = LAE_K_NONE;
        d.lenBytes   = `LAE_LEN_ONE;
        d.machCycles = `LAE_CYC_ONE;
        d.regIdx     = d.opcode[2:0];
        if ((d.opcode & `LAE_OPC_ACC_REG_MASK) == `LAE_OPC_ACC_REG) begin
            d.kind = LAE_K_ACC_REG;
        end else if (d.opcode == `LAE_OPC_ACC_DIR) begin
            d.kind     = LAE_K_ACC_DIR;
            d.lenBytes = `LAE_LEN_TWO;
        end else if ((d.opcode & `LAE_OPC_ACC_IND_MASK) == `LAE_OPC_ACC_IND) begin
            d.kind = LAE_K_ACC_IND;
        end else if (d.opcode == `LAE_OPC_ACC_IMM) begin
            d.kind     = LAE_K_ACC_IMM;
            d.lenBytes = `LAE_LEN_TWO;
        end else if (d.opcode == `LAE_OPC_DIR_ACC) begin
            d.kind     = LAE_K_DIR_ACC;
            d.lenBytes = `LAE_LEN_TWO;
        end else if (d.opcode == `LAE_OPC_DIR_IMM) begin
            d.kind       = LAE_K_DIR_IMM;
            d.lenBytes   = `LAE_LEN_THREE;
            d.machCycles = `LAE_CYC_TWO;
        end else if (d.opcode == `LAE_OPC_BIT) begin
            d.kind       = LAE_K_BIT;
            d.lenBytes   = `LAE_LEN_TWO;
            d.machCycles = `LAE_CYC_TWO;
        end else if (d.opcode == `LAE_OPC_BIT_NOT) begin
            d.kind       = LAE_K_BIT_NOT;
            d.lenBytes   = `LAE_LEN_TWO;
            d.machCycles = `LAE_CYC_TWO;
        end
    end
endmodule

// ### verilog/lae_pkg.sv
// Purpose: types shared by the logical AND decoder and executor
// Assumes: numbers live in lae_cfg.svh
// Notes:   state codes are one-hot
package lae_pkg;

    typedef enum logic [3:0] {
        LAE_K_NONE    = 4'h0,
        LAE_K_ACC_REG = 4'h1,
        LAE_K_ACC_DIR = 4'h2,
        LAE_K_ACC_IND = 4'h3,
        LAE_K_ACC_IMM = 4'h4,
        LAE_K_DIR_ACC = 4'h5,
        LAE_K_DIR_IMM = 4'h6,
        LAE_K_BIT     = 4'h7,
        LAE_K_BIT_NOT = 4'h8
    } lae_kind_t;

    typedef enum logic [6:0] {
        LAE_S_FETCH    = 7'h01,
        LAE_S_OPER     = 7'h02,
        LAE_S_PREP     = 7'h04,
        LAE_S_PTR_REQ  = 7'h08,
        LAE_S_PTR_DATA = 7'h10,
        LAE_S_REQ      = 7'h20,
        LAE_S_EXEC     = 7'h40
    } lae_state_t;

endpackage

// ### verilog/logical_and_execute.sv
// Purpose: fetch, decode and execute the byte and bit logical AND instructions
// Assumes: one-cycle synchronous data memory and bit read ports, accumulator held outside
// Notes:   cycles here are core clocks; documented byte and machine-cycle counts are reported
//
// Functional notes
// - opcode 0101 1rrr ANDs accumulator with working register, result to accumulator.
// - opcode 0101 0101 plus direct address ANDs accumulator with that byte.
// - opcode 0101 0111 ANDs accumulator with RAM byte at pointer register.
// - opcode 0101 0100 plus immediate ANDs accumulator with the constant.
// - opcode 0101 0010 plus direct address writes direct AND accumulator back there.
// - opcode 0101 0011, direct, immediate: direct AND constant back to direct, three bytes.
// - bit form clears carry when source bit is zero, else keeps carry.
// - complemented bit form uses inverse of the addressed bit.
// - addressed source bit is never written by the bit forms.
// - bit forms change no status flag other than carry.
// - bit source reached only through the direct bit address in the instruction.
// - byte forms change no status flag at all.
// - byte AND into a port reads the output latch, not the pins.
// - opcode 1000 0010 plus bit address ANDs carry with the bit.
// - opcode 1011 0000 plus bit address ANDs carry with the inverted bit.
`timescale 1ns/1ps
`include "lae_cfg.svh"
module logical_and_execute (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clkEn,
    input  wire logic       fetchValid,
    input  wire logic [7:0] fetchByte,
    output logic            fetchReady,
    input  wire logic [1:0] regBank,
    input  wire logic [7:0] accumulatorReg,
    output logic            memRdEn,
    output logic            memWrEn,
    output logic [7:0]      memAddr,
    output logic            memIndirect,
    output logic            memLatch,
    output logic [7:0]      memWrData,
    input  wire logic [7:0] memRdData,
    output logic            bitRdEn,
    output logic [7:0]      bitAddr,
    input  wire logic       bitRdData,
    output logic            accWrEn,
    output logic [7:0]      accWrData,
    output logic            carryWrEn,
    output logic            carryWrData,
    output logic            instDone,
    output logic            illegalOp,
    output logic [1:0]      instBytes,
    output logic [1:0]      instCycles
);
    import lae_pkg::*;

    typedef struct packed {
        lae_state_t st;
        lae_kind_t  kind;
        logic [2:0] regIdx;
        logic [1:0] lenBytes;
        logic [1:0] machCycles;
        logic [1:0] need;
        logic       opIdx;
        logic [7:0] op1;
        logic [7:0] op2;
        logic       fetchReady;
        logic       memRdEn;
        logic       memWrEn;
        logic [7:0] memAddr;
        logic       memIndirect;
        logic       memLatch;
        logic [7:0] memWrData;
        logic       bitRdEn;
        logic [7:0] bitAddr;
        logic       accWrEn;
        logic [7:0] accWrData;
        logic       carryWrEn;
        logic       carryWrData;
        logic       instDone;
        logic       illegalOp;
        logic [1:0] instBytes;
        logic [1:0] instCycles;
    } lae_regs_t;

    lae_regs_t r_q;
    lae_regs_t r_d;
    logic      take;
    logic      srcBit;

    lae_dec_if decBus ();

    lae_decode uDecode (
        .d (decBus)
    );

    assign decBus.opcode = fetchByte;
    assign take          = fetchValid && r_q.fetchReady;

    always_comb begin
        r_d             = r_q;
        r_d.memRdEn     = 1'b0;
        r_d.memWrEn     = 1'b0;
        r_d.bitRdEn     = 1'b0;
        r_d.accWrEn     = 1'b0;
        r_d.carryWrEn   = 1'b0;
        r_d.instDone    = 1'b0;
        r_d.illegalOp   = 1'b0;
        srcBit          = bitRdData ^ (r_q.kind == LAE_K_BIT_NOT);
        case (r_q.st)
            LAE_S_FETCH: begin
                r_d.fetchReady = 1'b1;
                if (take) begin
                    if (decBus.kind == LAE_K_NONE) begin
                        r_d.illegalOp = 1'b1;
                    end else begin
                        r_d.kind       = decBus.kind;
                        r_d.regIdx     = decBus.regIdx;
                        r_d.lenBytes   = decBus.lenBytes;
                        r_d.machCycles = decBus.machCycles;
                        r_d.need       = decBus.lenBytes - `LAE_LEN_ONE;
                        r_d.opIdx      = 1'b0;
                        if (decBus.lenBytes == `LAE_LEN_ONE) begin
                            r_d.fetchReady = 1'b0;
                            r_d.st         = LAE_S_PREP;
                        end else begin
                            r_d.st = LAE_S_OPER;
                        end
                    end
                end
            end
            LAE_S_OPER: begin
                if (take) begin
                    if (r_q.opIdx) begin
                        r_d.op2 = fetchByte;
                    end else begin
                        r_d.op1 = fetchByte;
                    end
                    r_d.opIdx = 1'b1;
                    r_d.need  = r_q.need - 2'h1;
                    if (r_q.need == 2'h1) begin
                        r_d.fetchReady = 1'b0;
                        r_d.st         = LAE_S_PREP;
                    end
                end
            end
            LAE_S_PREP: begin
                r_d.memIndirect = 1'b0;
                r_d.memLatch    = 1'b0;
                r_d.st          = LAE_S_REQ;
                case (r_q.kind)
                    LAE_K_ACC_REG: begin
                        r_d.memRdEn = 1'b1;
                        r_d.memAddr = {`LAE_RST_BANK_ADDR, regBank, r_q.regIdx};
                    end
                    LAE_K_ACC_IND: begin
                        r_d.memRdEn = 1'b1;
                        r_d.memAddr = {`LAE_RST_BANK_ADDR, regBank, 2'h0, r_q.regIdx[0]};
                        r_d.st      = LAE_S_PTR_REQ;
                    end
                    LAE_K_ACC_DIR: begin
                        r_d.memRdEn = 1'b1;
                        r_d.memAddr = r_q.op1;
                    end
                    LAE_K_DIR_ACC, LAE_K_DIR_IMM: begin
                        r_d.memRdEn  = 1'b1;
                        r_d.memAddr  = r_q.op1;
                        r_d.memLatch = 1'b1;
                    end
                    LAE_K_BIT, LAE_K_BIT_NOT: begin
                        r_d.bitRdEn = 1'b1;
                        r_d.bitAddr = r_q.op1;
                    end
                    default: begin
                        r_d.accWrEn    = 1'b1;
                        r_d.accWrData  = accumulatorReg & r_q.op1;
                        r_d.instDone   = 1'b1;
                        r_d.instBytes  = r_q.lenBytes;
                        r_d.instCycles = r_q.machCycles;
                        r_d.fetchReady = 1'b1;
                        r_d.st         = LAE_S_FETCH;
                    end
                endcase
            end
            LAE_S_PTR_REQ: begin
                r_d.st = LAE_S_PTR_DATA;
            end
            LAE_S_PTR_DATA: begin
                r_d.memRdEn     = 1'b1;
                r_d.memAddr     = memRdData;
                r_d.memIndirect = 1'b1;
                r_d.st          = LAE_S_REQ;
            end
            LAE_S_REQ: begin
                r_d.st = LAE_S_EXEC;
            end
            LAE_S_EXEC: begin
                case (r_q.kind)
                    LAE_K_DIR_ACC: begin
                        r_d.memWrEn   = 1'b1;
                        r_d.memWrData = memRdData & accumulatorReg;
                    end
                    LAE_K_DIR_IMM: begin
                        r_d.memWrEn   = 1'b1;
                        r_d.memWrData = memRdData & r_q.op2;
                    end
                    LAE_K_BIT, LAE_K_BIT_NOT: begin
                        // only a zero source touches carry; the bit itself is never written
                        r_d.carryWrEn   = ~srcBit;
                        r_d.carryWrData = 1'b0;
                    end
                    default: begin
                        r_d.accWrEn   = 1'b1;
                        r_d.accWrData = accumulatorReg & memRdData;
                    end
                endcase
                r_d.instDone   = 1'b1;
                r_d.instBytes  = r_q.lenBytes;
                r_d.instCycles = r_q.machCycles;
                r_d.fetchReady = 1'b1;
                r_d.st         = LAE_S_FETCH;
            end
            default: begin
                r_d.st         = LAE_S_FETCH;
                r_d.fetchReady = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r_q             <= '0;
            r_q.st          <= LAE_S_FETCH;
            r_q.kind        <= LAE_K_NONE;
            r_q.op1         <= `LAE_RST_BYTE;
            r_q.op2         <= `LAE_RST_BYTE;
            r_q.memAddr     <= `LAE_RST_BYTE;
            r_q.memWrData   <= `LAE_RST_BYTE;
            r_q.bitAddr     <= `LAE_RST_BYTE;
            r_q.accWrData   <= `LAE_RST_BYTE;
        end else if (clkEn) begin
            r_q <= r_d;
        end
    end

    assign fetchReady  = r_q.fetchReady;
    assign memRdEn     = r_q.memRdEn;
    assign memWrEn     = r_q.memWrEn;
    assign memAddr     = r_q.memAddr;
    assign memIndirect = r_q.memIndirect;
    assign memLatch    = r_q.memLatch;
    assign memWrData   = r_q.memWrData;
    assign bitRdEn     = r_q.bitRdEn;
    assign bitAddr     = r_q.bitAddr;
    assign accWrEn     = r_q.accWrEn;
    assign accWrData   = r_q.accWrData;
    assign carryWrEn   = r_q.carryWrEn;
    assign carryWrData = r_q.carryWrData;
    assign instDone    = r_q.instDone;
    assign illegalOp   = r_q.illegalOp;
    assign instBytes   = r_q.instBytes;
    assign instCycles  = r_q.instCycles;
endmodule
